/* File: pkg/conv_pkg.sv */
// Shared constants and types for the converter control block
package conv_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CFG_OFS    = 8'h04;
    localparam logic [7:0] CHAN_OFS   = 8'h08;
    localparam logic [7:0] PAIR_OFS   = 8'h0c;
    localparam logic [7:0] RES_HI_OFS = 8'h10;
    localparam logic [7:0] RES_LO_OFS = 8'h14;

    // Control register bit positions
    localparam int EN_BIT   = 7;
    localparam int TM_BIT   = 6;
    localparam int DONE_BIT = 5;
    localparam int BUSY_BIT = 4;
    localparam int CMHI_BIT = 3;
    localparam int CMLO_BIT = 2;
    localparam int LJ_BIT   = 0;

    // Config register fields: divider [15:8], gain [2:0]
    localparam int DIV_LSB  = 8;
    localparam int GAIN_LSB = 0;

    // Reset values
    localparam logic [7:0] DIV_RST  = 8'hff;
    localparam logic [2:0] GAIN_RST = 3'h0;

    // Gain codes; 3'h0 is unity
    localparam logic [2:0] GAIN_X1  = 3'h0;
    localparam logic [2:0] GAIN_X2  = 3'h1;
    localparam logic [2:0] GAIN_X4  = 3'h2;
    localparam logic [2:0] GAIN_X8  = 3'h3;
    localparam logic [2:0] GAIN_X16 = 3'h4;
    localparam logic [2:0] GAIN_X05 = 3'h6;

    // Conversion clock limits
    localparam int SYS_CLK_KHZ  = 250000;
    localparam int SAR_MAX_KHZ  = 2500;
    localparam int DIV_MIN      = (SYS_CLK_KHZ + SAR_MAX_KHZ - 1)
                                  / SAR_MAX_KHZ;
    localparam logic [3:0] CONV_TICKS  = 4'hf;
    localparam logic [1:0] TRACK_TICKS = 2'h3;
    localparam logic [3:0] TEMP_CHAN   = 4'h8;

    typedef enum logic [1:0] {
        START_SW  = 2'b00,
        START_T3  = 2'b01,
        START_EXT = 2'b10,
        START_T2  = 2'b11
    } start_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_TRACK   = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

endpackage : conv_pkg

/* File: rtl/conv_tick_gen.sv */
// Conversion clock tick generator divided from the system clock
`timescale 1ns/1ns
module conv_tick_gen
    import conv_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       restart_i,
    input  wire logic [7:0] div_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } tick_state_t;

    tick_state_t s_reg, s_next;
    logic [7:0]  div_eff;

    always_comb begin
        // Clamp keeps the rate within the converter limit
        div_eff = (div_i < 8'(DIV_MIN)) ? 8'(DIV_MIN) : div_i;
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (restart_i) begin
            s_next.cnt = div_eff - 8'h01;
        end else if (s_reg.cnt == 8'h00) begin
            s_next.cnt  = div_eff - 8'h01;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt - 8'h01;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_o = s_reg.tick;
endmodule : conv_tick_gen

/* File: rtl/conv_trigger_sel.sv */
// Start-of-conversion source selection and edge detection
`timescale 1ns/1ns
module conv_trigger_sel
    import conv_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       sw_start_i,
    input  wire logic       timer3_ovf_i,
    input  wire logic       timer2_ovf_i,
    input  wire logic       ext_convert_start_i,
    output logic            start_o
);
    typedef struct packed {
        logic ext_prev;
        logic start;
    } trig_state_t;

    trig_state_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.ext_prev = ext_convert_start_i;
        unique case (start_mode_t'(mode_i))
            START_SW:  s_next.start = sw_start_i;
            START_T3:  s_next.start = timer3_ovf_i;
            // Rising edge only; a held-high pin starts once
            START_EXT: s_next.start = ext_convert_start_i &
                                      !s_reg.ext_prev;
            START_T2:  s_next.start = timer2_ovf_i;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign start_o = s_reg.start;
endmodule : conv_trigger_sel

/* File: rtl/conv_ctrl.sv */
// Successive-approximation converter control with APB registers
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module conv_ctrl
    import conv_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        timer3_ovf_i,
    input  wire logic        timer2_ovf_i,
    input  wire logic        ext_convert_start_i,
    input  wire logic        chip_sleep_i,
    input  wire logic        cmp_i,
    output logic             analog_en_o,
    output logic             track_o,
    output logic [3:0]       mux_pos_o,
    output logic [3:0]       mux_neg_o,
    output logic             diff_mode_o,
    output logic [2:0]       gain_o,
    output logic [9:0]       dac_code_o,
    output logic             conv_busy_o,
    output logic             conv_done_o
);
    typedef struct packed {
        conv_state_t st;
        logic [3:0]  cnt;
        logic [9:0]  dac;
        logic [9:0]  mask;
        logic [9:0]  result;
        logic        conv_diff;
        logic        en;
        logic        tm;
        logic        done;
        logic [1:0]  cm;
        logic        ljst;
        logic [7:0]  div;
        logic [2:0]  gain;
        logic [3:0]  chan;
        logic [3:0]  pair;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        track;
        logic [3:0]  mux_pos;
        logic [3:0]  mux_neg;
        logic        diff;
        logic        busy;
    } ctrl_state_t;

    ctrl_state_t s_reg, s_next;
    logic        tick;
    logic        start;
    logic        sw_start;
    logic        wr_en;
    logic        busy;
    logic [7:0]  res_hi;
    logic [7:0]  res_lo;

    // Returns 1 when the channel sits in a differential pair
    function automatic logic pair_diff(input logic [3:0] chan,
                                       input logic [3:0] pair);
        if (chan[3]) begin
            pair_diff = 1'b0;
        end else begin
            pair_diff = pair[chan[2:1]];
        end
    endfunction : pair_diff

    assign busy  = s_reg.busy;
    assign wr_en = psel_i & penable_i & pwrite_i & s_reg.pready;
    assign sw_start = wr_en & (paddr_i == CTRL_OFS) &
                      pwdata_i[BUSY_BIT];

    conv_trigger_sel u_trig (
        .clock_i             (clock_i),
        .rst_n_i             (rst_n_i),
        .mode_i              (s_reg.cm),
        .sw_start_i          (sw_start),
        .timer3_ovf_i        (timer3_ovf_i),
        .timer2_ovf_i        (timer2_ovf_i),
        .ext_convert_start_i (ext_convert_start_i),
        .start_o             (start)
    );

    conv_tick_gen u_tick (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .restart_i (start & !busy),
        .div_i     (s_reg.div),
        .tick_o    (tick)
    );

    always_comb begin
        if (s_reg.ljst) begin
            res_hi = s_reg.result[9:2];
            res_lo = {s_reg.result[1:0], 6'h00};
        end else begin
            res_hi = {6'h00, s_reg.result[9:8]};
            res_lo = s_reg.result[7:0];
        end
    end

    always_comb begin
        s_next = s_reg;

        // APB: answer in the first access cycle
        s_next.pready  = psel_i & !penable_i;
        s_next.pslverr = 1'b0;
        if (psel_i & !penable_i) begin
            s_next.prdata = 32'h0000_0000;
            unique case (paddr_i)
                CTRL_OFS: begin
                    s_next.prdata[EN_BIT]   = s_reg.en;
                    s_next.prdata[TM_BIT]   = s_reg.tm;
                    s_next.prdata[DONE_BIT] = s_reg.done;
                    s_next.prdata[BUSY_BIT] = busy;
                    s_next.prdata[CMHI_BIT] = s_reg.cm[1];
                    s_next.prdata[CMLO_BIT] = s_reg.cm[0];
                    s_next.prdata[LJ_BIT]   = s_reg.ljst;
                end
                CFG_OFS: begin
                    s_next.prdata[DIV_LSB +: 8]  = s_reg.div;
                    s_next.prdata[GAIN_LSB +: 3] = s_reg.gain;
                end
                CHAN_OFS:   s_next.prdata[3:0] = s_reg.chan;
                PAIR_OFS:   s_next.prdata[3:0] = s_reg.pair;
                RES_HI_OFS: s_next.prdata[7:0] = res_hi;
                RES_LO_OFS: s_next.prdata[7:0] = res_lo;
                default:    s_next.pslverr = 1'b1;
            endcase
        end

        if (wr_en) begin
            unique case (paddr_i)
                CTRL_OFS: begin
                    s_next.en   = pwdata_i[EN_BIT];
                    s_next.tm   = pwdata_i[TM_BIT];
                    s_next.done = pwdata_i[DONE_BIT];
                    s_next.cm   = {pwdata_i[CMHI_BIT],
                                   pwdata_i[CMLO_BIT]};
                    s_next.ljst = pwdata_i[LJ_BIT];
                end
                CFG_OFS: begin
                    s_next.div  = pwdata_i[DIV_LSB +: 8];
                    s_next.gain = pwdata_i[GAIN_LSB +: 3];
                end
                CHAN_OFS: s_next.chan = pwdata_i[3:0];
                PAIR_OFS: s_next.pair = pwdata_i[3:0];
                default: begin
                end
            endcase
        end

        // Sequencer
        unique case (s_reg.st)
            ST_IDLE: begin
                if (start & s_reg.en) begin
                    s_next.cnt       = 4'h0;
                    s_next.conv_diff = pair_diff(s_reg.chan,
                                                 s_reg.pair);
                    s_next.dac       = 10'h200;
                    s_next.mask      = 10'h200;
                    // External low-power start converts at once
                    if (s_reg.tm && s_reg.cm != START_EXT) begin
                        s_next.st = ST_TRACK;
                    end else begin
                        s_next.st = ST_CONVERT;
                    end
                end
            end
            ST_TRACK: begin
                if (tick) begin
                    s_next.cnt = s_reg.cnt + 4'h1;
                    if (s_reg.cnt[1:0] == TRACK_TICKS - 2'h1) begin
                        s_next.cnt = 4'h0;
                        s_next.st  = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    s_next.cnt = s_reg.cnt + 4'h1;
                    if (s_reg.mask != 10'h000) begin
                        s_next.mask = s_reg.mask >> 1;
                        s_next.dac  = (cmp_i ? s_reg.dac
                                             : s_reg.dac & ~s_reg.mask)
                                      | (s_reg.mask >> 1);
                    end
                    if (s_reg.cnt == CONV_TICKS) begin
                        s_next.st     = ST_IDLE;
                        s_next.result = {s_reg.dac[9] ^
                                         s_reg.conv_diff,
                                         s_reg.dac[8:0]};
                        s_next.done   = 1'b1;
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase

        // Shutdown aborts any conversion in flight
        if (!s_next.en) begin
            s_next.st = ST_IDLE;
        end

        s_next.track = s_next.en & !chip_sleep_i &
            ((s_next.st == ST_TRACK) |
             ((s_next.st == ST_IDLE) &
              (!s_next.tm |
               (s_next.cm == START_EXT & !ext_convert_start_i))));
        s_next.diff    = pair_diff(s_next.chan, s_next.pair);
        s_next.mux_pos = s_next.chan[3] ? TEMP_CHAN
                       : (s_next.diff ? {s_next.chan[3:1], 1'b0}
                                      : s_next.chan);
        s_next.mux_neg = {s_next.chan[3:1], 1'b1};
        s_next.busy    = (s_next.st != ST_IDLE);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg      <= '0;
            s_reg.st   <= ST_IDLE;
            s_reg.div  <= DIV_RST;
            s_reg.gain <= GAIN_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Busy has its own flop, so the pin never glitches
    assign prdata_o    = s_reg.prdata;
    assign pready_o    = s_reg.pready;
    assign pslverr_o   = s_reg.pslverr;
    assign analog_en_o = s_reg.en;
    assign track_o     = s_reg.track;
    assign mux_pos_o   = s_reg.mux_pos;
    assign mux_neg_o   = s_reg.mux_neg;
    assign diff_mode_o = s_reg.diff;
    assign gain_o      = s_reg.gain;
    assign dac_code_o  = s_reg.dac;
    assign conv_busy_o = busy;
    assign conv_done_o = s_reg.done;

    a_disabled_idle: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) !s_reg.en |=> !busy)
        else $error("converter active while disabled");

    a_start_ignored: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        busy && start && !tick && s_reg.en
        |=> busy && $stable(s_reg.cnt) && $stable(s_reg.dac))
        else $error("start disturbed a conversion");

    a_busy_fall_done: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        $fell(busy) && s_reg.en |-> s_reg.done)
        else $error("done not set at end of conversion");

    a_conv_len: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        s_reg.st == ST_CONVERT && s_reg.cnt == CONV_TICKS && tick
        && s_reg.en |=> !busy)
        else $error("conversion did not end on sixteenth tick");

    a_track_start: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        s_reg.st == ST_IDLE && start && s_reg.en && s_reg.tm
        && s_reg.cm != START_EXT |=> s_reg.st == ST_TRACK)
        else $error("low-power track phase skipped");

    a_sleep_notrack: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        chip_sleep_i |=> !track_o)
        else $error("tracking during sleep");

    a_idle_track: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        !chip_sleep_i ##1 (s_reg.en && !s_reg.tm && !busy)
        |-> track_o)
        else $error("not tracking while idle");

    a_temp_select: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        s_reg.chan[3] |=> mux_pos_o == TEMP_CHAN
        || $changed(s_reg.chan))
        else $error("temperature sensor not routed");

    a_left_just: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        psel_i && !penable_i && paddr_i == RES_LO_OFS && s_reg.ljst
        |=> prdata_o[7:0] == 8'({$past(s_reg.result), 6'h00}))
        else $error("left justified low result wrong");

    c_sw_conv: cover property (@(posedge clock_i)
        disable iff (!rst_n_i) sw_start ##[1:3] busy);
    c_lp_track: cover property (@(posedge clock_i)
        disable iff (!rst_n_i) s_reg.st == ST_TRACK);
    c_diff_done: cover property (@(posedge clock_i)
        disable iff (!rst_n_i) $fell(busy) && s_reg.conv_diff);
endmodule : conv_ctrl

/* File: dv/conv_far_side.sv */
// Far-side model: comparator front end and timer overflow sources
`timescale 1ns/1ns
module conv_far_side #(
    parameter int T3_PERIOD = 500,
    parameter int T2_PERIOD = 700
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic [9:0] level_i,
    input  wire logic [9:0] dac_code_i,
    input  wire logic       t3_run_i,
    input  wire logic       t2_run_i,
    output logic            cmp_o,
    output logic            timer3_ovf_o,
    output logic            timer2_ovf_o
);
    int t3_cnt;
    int t2_cnt;
    // Periods shorter than a conversion, so some overflows land mid-run
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_o        <= 1'b0;
            t3_cnt       <= 0;
            t2_cnt       <= 0;
            timer3_ovf_o <= 1'b0;
            timer2_ovf_o <= 1'b0;
        end else begin
            cmp_o        <= (level_i >= dac_code_i);
            t3_cnt       <= t3_run_i ? (t3_cnt + 1) % T3_PERIOD : 0;
            t2_cnt       <= t2_run_i ? (t2_cnt + 1) % T2_PERIOD : 0;
            timer3_ovf_o <= t3_run_i && t3_cnt == T3_PERIOD - 1;
            timer2_ovf_o <= t2_run_i && t2_cnt == T2_PERIOD - 1;
        end
    end
endmodule : conv_far_side

/* File: dv/testbench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module testbench
    import conv_pkg::*;
;
    typedef struct packed {
        logic       tm;
        logic [1:0] md;
        logic       lj;
        logic [3:0] ch;
        logic [9:0] lv;
    } conv_case_t;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        t3_ovf, t2_ovf, ext, sleep, cmp, t3_run, t2_run;
    logic        analog_en, track, diff, busy, done;
    logic [3:0]  mux_pos, mux_neg;
    logic [2:0]  gain;
    logic [9:0]  dac, level;
    int          bad_count, comparisons;
    conv_ctrl conv_ctrl_i (.clock_i(clock), .rst_n_i(rst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .timer3_ovf_i(t3_ovf),
        .timer2_ovf_i(t2_ovf), .ext_convert_start_i(ext),
        .chip_sleep_i(sleep), .cmp_i(cmp), .analog_en_o(analog_en),
        .track_o(track), .mux_pos_o(mux_pos), .mux_neg_o(mux_neg),
        .diff_mode_o(diff), .gain_o(gain), .dac_code_o(dac),
        .conv_busy_o(busy), .conv_done_o(done));
    conv_far_side conv_far_side_i (.clock_i(clock), .rst_n_i(rst_n),
        .level_i(level), .dac_code_i(dac), .t3_run_i(t3_run),
        .t2_run_i(t2_run), .cmp_o(cmp), .timer3_ovf_o(t3_ovf),
        .timer2_ovf_o(t2_ovf));
    always #2 clock = ~clock;
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Holds the request until pready is sampled high, then releases
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        check("apb_ready", 1, pready);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd
    function automatic logic [31:0] ctl(input logic tm,
        input logic [1:0] md, input logic lj, input logic go);
        ctl = 32'h80 | (32'(tm) << TM_BIT) | (32'(go) << BUSY_BIT)
            | (32'(md) << CMLO_BIT) | (32'(lj) << LJ_BIT);
    endfunction : ctl
    // Busy length is a window since the first tick phase may slip by one
    task automatic result_check(input int ticks, input logic [9:0] r,
                                input logic lj);
        int          n;
        int          len;
        logic [31:0] q;
        n = 0;
        len = 0;
        while (busy !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        while (busy === 1'b1 && len < 5000) begin
            @(posedge clock);
            len++;
        end
        check("busy_len", 1, 32'(len >= ticks * 100 - 2
                                 && len <= ticks * 100 + 2));
        check("done_pin", 1, done);
        rd(CTRL_OFS, q);
        check("done", 1, q[DONE_BIT]);
        check("busy_bit", 0, q[BUSY_BIT]);
        rd(RES_HI_OFS, q);
        check("res_hi", lj ? 32'(r[9:2]) : 32'(r[9:8]), q);
        rd(RES_LO_OFS, q);
        check("res_lo", lj ? 32'({r[1:0], 6'h0}) : 32'(r[7:0]), q);
    endtask : result_check
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        finish_test();
    end
    initial begin
        logic [31:0] q;
        logic        e;
        logic [9:0]  r;
        logic [2:0]  gains[6];
        conv_case_t  cases[5];
        gains = '{GAIN_X05, GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16, GAIN_X1};
        cases = '{'{1'b0, START_SW, 1'b0, 4'h8, 10'h2a5},
                  '{1'b1, START_SW, 1'b1, 4'h0, 10'h133},
                  '{1'b0, START_T3, 1'b0, 4'h0, 10'h3c1},
                  '{1'b0, START_T2, 1'b1, 4'h3, 10'h05a},
                  '{1'b1, START_EXT, 1'b0, 4'h3, 10'h200}};
        {clock, rst_n, psel, penable, pwrite, sleep, ext} = '0;
        {t3_run, t2_run, paddr, pwdata, level} = '0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(CTRL_OFS, q);
        check("ctrl_rst", 0, q);
        rd(CFG_OFS, q);
        check("cfg_rst", {16'h0, DIV_RST, 5'h0, GAIN_RST}, q);
        rd(PAIR_OFS, q);
        check("pair_rst", 0, q);
        apb(1'b0, 8'h18, 32'h0, q, e);
        check("unmapped_err", 1, e);
        check("unmapped_data", 0, q);
        check("analog_off", 0, analog_en);
        $display("test reset done");
        foreach (gains[i]) begin
            wr(CFG_OFS, {16'h0, 8'h64, 5'h0, gains[i]});
            check("gain", gains[i], gain);
        end
        wr(CTRL_OFS, ctl(1'b0, START_SW, 1'b0, 1'b0));
        check("analog_on", 1, analog_en);
        check("track_idle", 1, track);
        sleep <= 1'b1;
        repeat (3) @(posedge clock);
        check("track_sleep", 0, track);
        sleep <= 1'b0;
        wr(CHAN_OFS, 32'h8);
        check("mux_temp", 4'h8, mux_pos);
        wr(PAIR_OFS, 32'h1);
        wr(CHAN_OFS, 32'h0);
        check("diff_on", 1, diff);
        check("mux_neg", 4'h1, mux_neg);
        wr(CHAN_OFS, 32'h3);
        check("diff_off", 0, diff);
        $display("test mux done");
        foreach (cases[i]) begin
            ext   <= 1'b0;
            level <= cases[i].lv;
            wr(CHAN_OFS, 32'(cases[i].ch));
            // Clearing done first, as software must
            wr(CTRL_OFS, ctl(cases[i].tm, cases[i].md, cases[i].lj,
                             1'b0));
            if (cases[i].tm)
                check("track_lp", cases[i].md == START_EXT,
                      track);
            case (cases[i].md)
                START_SW:  wr(CTRL_OFS, ctl(cases[i].tm, START_SW,
                                            cases[i].lj, 1'b1));
                START_T3:  t3_run <= 1'b1;
                START_T2:  t2_run <= 1'b1;
                default:   ext <= 1'b1;
            endcase
            r = (cases[i].ch == 4'h0) ? cases[i].lv ^ 10'h200 : cases[i].lv;
            result_check((cases[i].tm && cases[i].md != START_EXT)
                         ? 19 : 16, r, cases[i].lj);
            // Low-power mode must not track once idle with the pin high
            if (cases[i].tm)
                check("track_hold", 0, track);
            t3_run <= 1'b0;
            t2_run <= 1'b0;
            wr(CTRL_OFS, 32'h0);
            check("abort_off", 0, analog_en | track);
            $display("test conversion %0d done", i);
        end
        finish_test();
    end
endmodule : testbench
